// *** pkg/block_queue_regs.vh ***
/*
 * Register offsets, field positions, reset values and limits of the
 * command block storage and inbound queue. Definitions only.
 * Assumes an 8-bit register address space shared by host and sequencer.
 */
`ifndef BLOCK_QUEUE_REGS_VH
`define BLOCK_QUEUE_REGS_VH

`define PAGE_PTR_ADDR    8'h90
`define OFS_CNT_ADDR     8'h9A
`define IN_QUEUE_ADDR    8'h9B
`define IN_QCOUNT_ADDR   8'h9C
`define WIN_LO_ADDR      8'hA0
`define WIN_HI_ADDR      8'hBF

`define AUTO_BIT         7
`define CNT_MSB          4
`define PAGE_BYTES       32

`define PAGE_PTR_RST     8'h00
`define OFS_CNT_RST      8'h00
`define QCOUNT_RST       8'h00
`define QCOUNT_MAX       8'hFF
`define QCOUNT_EMPTY     8'h00
`define LAST_LANE        2'h3

`define STAGE_DEPTH      8
`define STAGE_AW         3
`define RAM_AW           9

`endif

// *** verilog/stage_fifo.v ***
/*
 * Small synchronous FIFO that stages inbound queue entries.
 * Assumes both sides run on mclk; in_ready and out_valid are honest.
 */
`timescale 1ns/1ps
module stage_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk,
    input  wire             nrst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wp_ff;
    reg [AW-1:0]    rp_ff;
    reg [AW:0]      lvl_ff;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (lvl_ff != DEPTH[AW:0]);
    assign out_valid = (lvl_ff != {(AW+1){1'b0}});
    assign out_data  = mem_ff[rp_ff];

    always @(posedge mclk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            wp_ff  <= {AW{1'b0}};
            rp_ff  <= {AW{1'b0}};
            lvl_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
            if (push && !pop) begin
                lvl_ff <= lvl_ff + 1'b1;
            end else if (pop && !push) begin
                lvl_ff <= lvl_ff - 1'b1;
            end
        end
    end
endmodule // stage_fifo

// *** verilog/block_ram.v ***
/*
 * Internal block memory: byte wide, synchronous write and read.
 * Assumes one access per cycle; read data follows the address by one edge.
 */
`timescale 1ns/1ps
module block_ram #(
    parameter AW = 9,
    parameter DW = 8
) (
    input  wire          mclk,
    input  wire          nrst,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem_ff [0:(1<<AW)-1];

    always @(posedge mclk) begin
        if (we) begin
            mem_ff[addr] <= wdata;
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            rdata <= {DW{1'b0}};
        end else begin
            rdata <= mem_ff[addr];
        end
    end
endmodule // block_ram

// *** verilog/command_block_array_queue.v ***
/*
 * Command block storage access and inbound command queue.
 * Host accesses arrive already decoded from the bus target; the sequencer
 * and the external memory port controller are logic on the same mclk.
 */
// What this block does
// RULE1 - Page pointer selects one 32-byte page for every block access.
// RULE2 - Changing the page pointer never alters stored block contents.
// RULE3 - Page pointer reads back all eight bits, FFh included, in any mode.
// RULE4 - Auto-address bit makes the counter supply the byte offset.
// RULE5 - In counter mode the offset counter increments after every block byte accessed.
// RULE6 - Counter mode shares one address; else sequencer reads and writes differ.
// RULE7 - Sequencer accesses to block storage are always single bytes.
// RULE8 - Without auto-address, host accesses to block storage are bytes only.
// RULE9 - Auto-address: host reads bytes; one enable byte write, four enables dword.
// RULE10 - Counter bits 4:2 pick the dword, bits 1:0 the byte within it.
// RULE11 - Dword write unpacks from the counter's byte through byte three; ready only after byte three written.
// RULE12 - Internal storage bursts without disconnect; external storage may disconnect.
// RULE13 - Accessors keep repeated counter-mode addresses inside the block window.
// RULE14 - Host write pushes a page number; each sequencer read pops one.
// RULE15 - Queue holds 16 entries internally, 255 with external storage.
// RULE16 - Writes ignored at count 255, reads ignored at count 0.
// RULE17 - Internal mode entries read zero in bits 7:4; external keeps them.
// RULE18 - Readers trust a queue value only while the count is non-zero.
// RULE19 - Count register reports valid entries; zero means empty.
// RULE20 - Internally count bits 7:4 show rollover; externally all eight count.
// RULE21 - External mode reuses internal block memory as queue storage.
// RULE22 - External storage mode places block data in external static memory.
// RULE23 - Reset clears pointer, counter, auto bit and count; queue empty.
`timescale 1ns/1ps
`include "block_queue_regs.vh"
module command_block_array_queue (
    input  wire        mclk,
    input  wire        nrst,
    input  wire        external_storage_mode,
    input  wire        h_sel,
    input  wire        h_write,
    input  wire [7:0]  h_addr,
    input  wire [3:0]  cbe_n,
    input  wire [31:0] h_wdata,
    output wire        h_ready,
    output wire        h_disconnect,
    input  wire        seq_rd,
    input  wire        seq_wr,
    input  wire [7:0]  seq_raddr,
    input  wire [7:0]  seq_waddr,
    input  wire [7:0]  seq_wdata,
    output wire        seq_ack,
    output wire [7:0]  rdata,
    output wire        ext_req,
    output wire        ext_we,
    output wire [12:0] ext_addr,
    output wire [7:0]  ext_wdata,
    input  wire        ext_ack,
    input  wire [7:0]  ext_rdata
);
    localparam S_IDLE = 2'd0;
    localparam S_EXEC = 2'd1;
    localparam S_RDW  = 2'd2;
    localparam S_EXT  = 2'd3;

    function in_win;
        input [7:0] a;
        begin
            in_win = (a >= `WIN_LO_ADDR) && (a <= `WIN_HI_ADDR);
        end
    endfunction

    function [1:0] lane_of;
        input [3:0] be;
        begin
            if (be[0]) begin
                lane_of = 2'd0;
            end else if (be[1]) begin
                lane_of = 2'd1;
            end else if (be[2]) begin
                lane_of = 2'd2;
            end else begin
                lane_of = 2'd3;
            end
        end
    endfunction

    reg  [1:0]  state_ff;
    reg  [7:0]  ptr_ff;
    reg         auto_ff;
    reg  [4:0]  cnt_ff;
    reg  [7:0]  qcnt_ff;
    reg  [7:0]  qwp_ff;
    reg  [7:0]  qrp_ff;
    reg  [7:0]  qsmall_ff [0:15];
    reg         cur_seq_ff;
    reg         cur_we_ff;
    reg  [7:0]  cur_addr_ff;
    reg  [31:0] cur_word_ff;
    reg  [1:0]  cur_lane_ff;
    reg         cur_dw_ff;
    reg  [4:0]  last_ofs_ff;
    reg  [7:0]  rdata_ff;
    reg         h_ready_ff;
    reg         h_disc_ff;
    reg         seq_ack_ff;
    reg         ext_req_ff;
    reg         ext_we_ff;
    reg  [12:0] ext_addr_ff;
    reg  [7:0]  ext_wdata_ff;
    reg         ram_we;
    reg  [8:0]  ram_addr;
    reg  [7:0]  ram_wd;
    wire [7:0]  ram_rd;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [7:0]  fifo_out;
    wire [7:0]  ofs_cnt_rst = `OFS_CNT_RST;

    // A source is not retaken in the cycle its completion pulse is visible.
    wire       sel_seq  = (seq_rd || seq_wr) && !seq_ack_ff;
    wire       sel_host = !sel_seq && h_sel && !h_ready_ff;
    wire       r_we     = sel_seq ? !seq_rd : h_write;
    wire [7:0] r_addr   = sel_seq ? (seq_rd ? seq_raddr : seq_waddr) : h_addr;
    wire [1:0] r_lane   = lane_of(~cbe_n);
    wire       r_dw     = sel_host && h_write && auto_ff && (cbe_n == 4'h0)
                          && in_win(h_addr);                        // [RULE9]
    wire       take     = (state_ff == S_IDLE) && (sel_seq || sel_host);
    // Back-pressure: a queue write below count 255 waits while the staging FIFO is full.
    wire       stall    = r_we && (r_addr == `IN_QUEUE_ADDR)
                          && (qcnt_ff != `QCOUNT_MAX) && !fifo_in_ready;
    wire       go       = take && !stall;
    wire       push     = go && r_we && (r_addr == `IN_QUEUE_ADDR)
                          && (qcnt_ff != `QCOUNT_MAX);              // [RULE14] [RULE16]
    wire       drain    = (state_ff == S_IDLE) && !go && fifo_out_valid;

    wire       cur_win  = in_win(cur_addr_ff);
    wire [4:0] ofs      = auto_ff ? cnt_ff : cur_addr_ff[4:0];     // [RULE4] [RULE6]
    wire [1:0] bsel     = cur_dw_ff ? cnt_ff[1:0] : cur_lane_ff;   // [RULE10]
    wire [7:0] wbyte    = cur_word_ff[{bsel, 3'b000} +: 8];
    wire       que_rd   = (state_ff == S_EXEC) && !cur_we_ff
                          && (cur_addr_ff == `IN_QUEUE_ADDR);
    wire       q_pop    = que_rd && (qcnt_ff != `QCOUNT_EMPTY);    // [RULE16]
    wire [7:0] q_head   = qsmall_ff[qrp_ff[3:0]];

    assign h_ready      = h_ready_ff;
    assign h_disconnect = h_disc_ff;
    assign seq_ack      = seq_ack_ff;
    assign rdata        = rdata_ff;
    assign ext_req      = ext_req_ff;
    assign ext_we       = ext_we_ff;
    assign ext_addr     = ext_addr_ff;
    assign ext_wdata    = ext_wdata_ff;

    // Single memory port: block access, queue read or queue drain.
    always @* begin
        ram_we   = 1'b0;
        ram_addr = 9'h000;
        ram_wd   = wbyte;
        if (state_ff == S_EXEC && cur_win && !external_storage_mode) begin
            ram_we   = cur_we_ff;
            ram_addr = {ptr_ff[3:0], ofs};                          // [RULE1]
        end else if (q_pop && external_storage_mode) begin
            ram_addr = {1'b0, qrp_ff};                              // [RULE21]
        end else if (drain && external_storage_mode) begin
            ram_we   = (qcnt_ff != `QCOUNT_MAX);
            ram_addr = {1'b0, qwp_ff};                              // [RULE21]
            ram_wd   = fifo_out;
        end
    end

    block_ram #(
        .AW    (`RAM_AW),
        .DW    (8)
    ) u_ram (
        .mclk  (mclk),
        .nrst  (nrst),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wd),
        .rdata (ram_rd)
    );

    stage_fifo #(
        .WIDTH     (8),
        .DEPTH     (`STAGE_DEPTH),
        .AW        (`STAGE_AW)
    ) u_stage (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (sel_seq ? seq_wdata : h_wdata[{r_lane, 3'b000} +: 8]),
        .out_valid (fifo_out_valid),
        .out_ready (drain),
        .out_data  (fifo_out)
    );

    // Internal-mode queue storage is separate so block contents stay intact.
    always @(posedge mclk) begin
        if (drain && !external_storage_mode && qcnt_ff != `QCOUNT_MAX) begin
            qsmall_ff[qwp_ff[3:0]] <= fifo_out;                     // [RULE15]
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            state_ff     <= S_IDLE;
            ptr_ff       <= `PAGE_PTR_RST;                          // [RULE23]
            {auto_ff, cnt_ff} <= {ofs_cnt_rst[`AUTO_BIT], ofs_cnt_rst[`CNT_MSB:0]};
            qcnt_ff      <= `QCOUNT_RST;
            qwp_ff       <= 8'h00;
            qrp_ff       <= 8'h00;
            cur_seq_ff   <= 1'b0;
            cur_we_ff    <= 1'b0;
            cur_addr_ff  <= 8'h00;
            cur_word_ff  <= 32'h0000_0000;
            cur_lane_ff  <= 2'd0;
            cur_dw_ff    <= 1'b0;
            last_ofs_ff  <= 5'h00;
            rdata_ff     <= 8'h00;
            h_ready_ff   <= 1'b0;
            h_disc_ff    <= 1'b0;
            seq_ack_ff   <= 1'b0;
            ext_req_ff   <= 1'b0;
            ext_we_ff    <= 1'b0;
            ext_addr_ff  <= 13'h0000;
            ext_wdata_ff <= 8'h00;
        end else begin
            h_ready_ff <= 1'b0;
            h_disc_ff  <= 1'b0;
            seq_ack_ff <= 1'b0;
            if (drain && qcnt_ff != `QCOUNT_MAX) begin
                qwp_ff  <= qwp_ff + 8'h01;
                qcnt_ff <= qcnt_ff + 8'h01;                         // [RULE19] [RULE20]
            end
            case (state_ff)
                S_IDLE: begin
                    if (go) begin
                        cur_seq_ff  <= sel_seq;
                        cur_we_ff   <= r_we;
                        cur_addr_ff <= r_addr;
                        cur_word_ff <= sel_seq ? {24'h00_0000, seq_wdata} : h_wdata;
                        cur_lane_ff <= sel_seq ? 2'd0 : r_lane;     // [RULE7] [RULE8]
                        cur_dw_ff   <= r_dw;
                        state_ff    <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    if (cur_win) begin
                        last_ofs_ff <= ofs;
                        if (auto_ff) begin
                            cnt_ff <= cnt_ff + 5'h01;               // [RULE5] [RULE11] [RULE13]
                        end
                        if (external_storage_mode) begin
                            ext_req_ff   <= 1'b1;                   // [RULE22]
                            ext_we_ff    <= cur_we_ff;
                            ext_addr_ff  <= {ptr_ff, ofs};          // [RULE1] [RULE2]
                            ext_wdata_ff <= wbyte;
                            state_ff     <= S_EXT;
                        end else if (!cur_we_ff) begin
                            state_ff <= S_RDW;
                        end else if (cur_dw_ff && ofs[1:0] != `LAST_LANE) begin
                            state_ff <= S_EXEC;                     // [RULE11]
                        end else begin
                            state_ff   <= S_IDLE;
                            h_ready_ff <= !cur_seq_ff;              // [RULE12]
                            seq_ack_ff <= cur_seq_ff;
                        end
                    end else begin
                        state_ff   <= S_IDLE;
                        h_ready_ff <= !cur_seq_ff;
                        seq_ack_ff <= cur_seq_ff;
                        rdata_ff   <= 8'h00;
                        case (cur_addr_ff)
                            `PAGE_PTR_ADDR: begin
                                if (cur_we_ff) begin
                                    ptr_ff <= wbyte;                // [RULE1] [RULE2]
                                end else begin
                                    rdata_ff <= ptr_ff;             // [RULE3]
                                end
                            end
                            `OFS_CNT_ADDR: begin
                                if (cur_we_ff) begin
                                    auto_ff <= wbyte[`AUTO_BIT];
                                    cnt_ff  <= wbyte[`CNT_MSB:0];
                                end else begin
                                    rdata_ff <= {auto_ff, 2'b00, cnt_ff};
                                end
                            end
                            `IN_QUEUE_ADDR: begin
                                if (q_pop) begin
                                    qrp_ff  <= qrp_ff + 8'h01;      // [RULE14]
                                    qcnt_ff <= qcnt_ff - 8'h01;     // [RULE19]
                                    if (external_storage_mode) begin
                                        h_ready_ff <= 1'b0;
                                        seq_ack_ff <= 1'b0;
                                        state_ff   <= S_RDW;
                                    end else begin
                                        rdata_ff <= {4'h0, q_head[3:0]}; // [RULE17]
                                    end
                                end
                            end
                            `IN_QCOUNT_ADDR: begin
                                if (!cur_we_ff) begin
                                    rdata_ff <= qcnt_ff;            // [RULE19] [RULE20]
                                end
                            end
                            default: begin
                                rdata_ff <= 8'h00;
                            end
                        endcase
                    end
                end
                S_RDW: begin
                    // Full byte: block data, or an external-mode queue entry.
                    rdata_ff   <= ram_rd;                           // [RULE17]
                    state_ff   <= S_IDLE;
                    h_ready_ff <= !cur_seq_ff;
                    seq_ack_ff <= cur_seq_ff;
                end
                S_EXT: begin
                    if (ext_ack) begin
                        ext_req_ff <= 1'b0;
                        if (!cur_we_ff) begin
                            rdata_ff <= ext_rdata;
                        end
                        if (cur_dw_ff && last_ofs_ff[1:0] != `LAST_LANE) begin
                            state_ff <= S_EXEC;                     // [RULE11]
                        end else begin
                            state_ff   <= S_IDLE;
                            h_ready_ff <= !cur_seq_ff;
                            h_disc_ff  <= !cur_seq_ff;              // [RULE12]
                            seq_ack_ff <= cur_seq_ff;
                        end
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule // command_block_array_queue

// *** bench/ext_mem_model.sv ***
/*
 * External block memory behind the memory port: answers ext_req with ext_ack,
 * alternating a prompt and a three-cycle answer.
 * Assumes ext_req is held with steady address and data until ext_ack.
 */
`timescale 1ns/1ps
module ext_mem_model (
    input  wire        mclk,
    input  wire        ext_req,
    input  wire        ext_we,
    input  wire [12:0] ext_addr,
    input  wire [7:0]  ext_wdata,
    output reg         ext_ack,
    output wire [7:0]  ext_rdata
);
    reg [7:0] mem [0:8191];
    reg [1:0] wait_ff;
    reg       slow_ff;
    reg [7:0] data_ff;

    // Outside an answer the data lines show the inverse of the last byte.
    assign ext_rdata = ext_ack ? data_ff : ~data_ff;

    initial begin
        ext_ack = 1'b0;
        wait_ff = 2'd0;
        slow_ff = 1'b0;
        data_ff = 8'h00;
    end

    always @(posedge mclk) begin
        ext_ack <= 1'b0;
        if (ext_req && !ext_ack) begin
            wait_ff <= wait_ff + 2'd1;
            if (wait_ff == (slow_ff ? 2'd3 : 2'd0)) begin
                ext_ack <= 1'b1;
                wait_ff <= 2'd0;
                slow_ff <= ~slow_ff;
                if (ext_we) mem[ext_addr] <= ext_wdata;
                else data_ff <= mem[ext_addr];
            end
        end
    end
endmodule // ext_mem_model

// *** bench/command_block_array_queue_chk.sv ***
/*
 * Port assertions for the block storage and inbound queue.
 * Assumes one access in flight at a time, as the bench drives.
 */
`timescale 1ns/1ps
module command_block_array_queue_chk (
    input wire        mclk,
    input wire        nrst,
    input wire        external_storage_mode,
    input wire        h_sel,
    input wire        h_write,
    input wire [7:0]  h_addr,
    input wire [3:0]  cbe_n,
    input wire [31:0] h_wdata,
    input wire        h_ready,
    input wire        h_disconnect,
    input wire        seq_rd,
    input wire        seq_wr,
    input wire [7:0]  seq_raddr,
    input wire [7:0]  seq_waddr,
    input wire [7:0]  seq_wdata,
    input wire        seq_ack,
    input wire [7:0]  rdata,
    input wire        ext_req,
    input wire        ext_we,
    input wire [12:0] ext_addr,
    input wire [7:0]  ext_wdata,
    input wire        ext_ack,
    input wire [7:0]  ext_rdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire blk = (h_addr >= 8'hA0) && (h_addr <= 8'hBF);
    wire quiet = !seq_rd && !seq_wr;

    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !h_ready && !seq_ack && !ext_req && rdata == 8'h00) else $error("reset");
    a_ptr_answer: assert property (
        $rose(h_sel) && h_addr == 8'h90 && quiet |-> !h_ready [*2] ##1 h_ready)
        else $error("pointer access timing");
    a_dword_wait: assert property (
        $rose(h_sel) && h_write && cbe_n == 4'h0 && blk && !external_storage_mode && quiet
        |-> !h_ready [*2] ##[1:4] h_ready) else $error("dword unpack timing");
    a_blk_read: assert property (
        $rose(h_sel) && !h_write && blk && !external_storage_mode && quiet
        |-> ##3 h_ready && !h_disconnect) else $error("block read timing");
    a_disc_ext: assert property (h_disconnect |-> h_ready && external_storage_mode)
        else $error("disconnect misplaced");
    a_count_answer: assert property ($rose(seq_rd) && seq_raddr == 8'h9C && !h_sel
        |-> ##2 seq_ack) else $error("count read timing");
    a_ready_pulse: assert property (h_ready |=> !h_ready)
        else $error("ready too long");
    a_ack_pulse: assert property (seq_ack |=> !seq_ack)
        else $error("ack too long");
    a_ext_hold: assert property (ext_req && !ext_ack
        |=> ext_req && $stable(ext_addr) && $stable(ext_we)) else $error("memory request dropped");
    a_ext_only: assert property ($rose(ext_req) |-> external_storage_mode)
        else $error("memory request in internal mode");
endmodule // command_block_array_queue_chk

bind command_block_array_queue command_block_array_queue_chk command_block_array_queue_chk_i (
    .mclk(mclk), .nrst(nrst), .external_storage_mode(external_storage_mode),
    .h_sel(h_sel), .h_write(h_write), .h_addr(h_addr), .cbe_n(cbe_n), .h_wdata(h_wdata),
    .h_ready(h_ready), .h_disconnect(h_disconnect), .seq_rd(seq_rd), .seq_wr(seq_wr),
    .seq_raddr(seq_raddr), .seq_waddr(seq_waddr), .seq_wdata(seq_wdata), .seq_ack(seq_ack),
    .rdata(rdata), .ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

// *** bench/command_block_array_queue_tb.sv ***
/*
 * Self-checking bench: host and sequencer register accesses with expected values.
 * Assumes the memory model answers external block accesses.
 */
`timescale 1ns/1ps
module command_block_array_queue_tb;
    reg         mclk, nrst, external_storage_mode;
    reg         h_sel, h_write, seq_rd, seq_wr;
    reg  [7:0]  h_addr, seq_raddr, seq_waddr, seq_wdata;
    reg  [3:0]  cbe_n;
    reg  [31:0] h_wdata;
    wire        h_ready, h_disconnect, seq_ack, ext_req, ext_we, ext_ack;
    wire [7:0]  rdata, ext_wdata, ext_rdata;
    wire [12:0] ext_addr;
    reg  [7:0]  hd, sd;
    reg         hdisc;
    integer     fail_count, samples_checked, cycles, i;

    command_block_array_queue command_block_array_queue_i (
        .mclk(mclk), .nrst(nrst), .external_storage_mode(external_storage_mode),
        .h_sel(h_sel), .h_write(h_write), .h_addr(h_addr), .cbe_n(cbe_n),
        .h_wdata(h_wdata), .h_ready(h_ready), .h_disconnect(h_disconnect),
        .seq_rd(seq_rd), .seq_wr(seq_wr), .seq_raddr(seq_raddr), .seq_waddr(seq_waddr),
        .seq_wdata(seq_wdata), .seq_ack(seq_ack), .rdata(rdata), .ext_req(ext_req),
        .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ack(ext_ack),
        .ext_rdata(ext_rdata));

    ext_mem_model ext_mem_model_i (.mclk(mclk), .ext_req(ext_req), .ext_we(ext_we),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task print_verdict;
        begin
            if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // Request is held past the edge that samples ready, then released.
    task host(input wr, input [7:0] a, input [3:0] be, input [31:0] wd);
        integer n;
        begin
            @(negedge mclk);
            h_sel = 1'b1; h_write = wr; h_addr = a; cbe_n = be; h_wdata = wd;
            for (n = 0; n < 2000 && h_ready !== 1'b1; n = n + 1) @(negedge mclk);
            if (n == 2000) fail_count = fail_count + 1;
            hd = rdata;
            hdisc = h_disconnect;
            @(negedge mclk);
            h_sel = 1'b0; h_write = 1'b0; h_wdata = ~wd;
        end
    endtask

    task seq(input rd, input [7:0] a, input [7:0] wd);
        integer n;
        begin
            @(negedge mclk);
            seq_rd = rd; seq_wr = !rd; seq_wdata = wd;
            seq_raddr = rd ? a : 8'hB0;
            seq_waddr = rd ? 8'hB0 : a;
            for (n = 0; n < 2000 && seq_ack !== 1'b1; n = n + 1) @(negedge mclk);
            if (n == 2000) fail_count = fail_count + 1;
            sd = rdata;
            @(negedge mclk);
            seq_rd = 1'b0; seq_wr = 1'b0;
        end
    endtask

    task hr(input [7:0] a);
        host(1'b0, a, 4'hE, 32'h0000_0000);
    endtask

    task hw(input [7:0] a, input [7:0] v);
        host(1'b1, a, 4'hE, {24'h00_0000, v});
    endtask

    task wait_count(input [7:0] exp);
        integer k;
        begin
            hd = ~exp;
            for (k = 0; k < 40 && hd !== exp; k = k + 1) hr(8'h9C);
            check(hd, exp);
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end

    initial begin
        fail_count = 0; samples_checked = 0; cycles = 0;
        nrst = 1'b0; external_storage_mode = 1'b0; h_sel = 1'b0; h_write = 1'b0;
        h_addr = 8'h00; cbe_n = 4'hF; h_wdata = 32'h0000_0000; seq_rd = 1'b0;
        seq_wr = 1'b0; seq_raddr = 8'h00; seq_waddr = 8'h00; seq_wdata = 8'h00;
        repeat (8) @(posedge mclk);
        @(negedge mclk) nrst = 1'b1;
        hr(8'h90); check(hd, 8'h00);
        hr(8'h9A); check(hd, 8'h00);
        hr(8'h9C); check(hd, 8'h00);
        hw(8'h91, 8'h5A); hr(8'h91); check(hd, 8'h00);
        hw(8'h90, 8'hFF); hr(8'h90); check(hd, 8'hFF);
        hw(8'h90, 8'h01); hw(8'hA5, 8'h11); hw(8'h90, 8'h02); hw(8'hA5, 8'h22);
        hw(8'h90, 8'h01); hr(8'hA5); check(hd, 8'h11);
        hw(8'h90, 8'h02); hr(8'hA5); check(hd, 8'h22);
        hw(8'h9A, 8'h84); host(1'b1, 8'hA0, 4'h0, 32'h4433_2211);
        check(hdisc, 1'b0);
        hr(8'h9A); check(hd, 8'h88);
        hw(8'h9A, 8'h8A); host(1'b1, 8'hA0, 4'h0, 32'hDDCC_BBAA);
        hr(8'h9A); check(hd, 8'h8C);
        hw(8'h9A, 8'h84);
        for (i = 0; i < 4; i = i + 1) begin
            hr(8'hB7);
            check(hd, 8'h11 * (i + 1));
        end
        hw(8'h9A, 8'h8A);
        seq(1'b1, 8'hA0, 8'h00); check(sd, 8'hCC);
        seq(1'b1, 8'hA0, 8'h00); check(sd, 8'hDD);
        hw(8'h9A, 8'h00);
        seq(1'b0, 8'hA3, 8'h5A); seq(1'b1, 8'hA3, 8'h00); check(sd, 8'h5A);
        hr(8'hA6); check(hd, 8'h33);
        host(1'b1, 8'hA8, 4'hD, 32'h0000_7700); hr(8'hA8); check(hd, 8'h77);
        hw(8'h9B, 8'h3C); hw(8'h9B, 8'h05); wait_count(8'h02);
        seq(1'b1, 8'h9C, 8'h00); check(sd, 8'h02);
        seq(1'b1, 8'h9B, 8'h00); check(sd, 8'h0C);
        seq(1'b1, 8'h9B, 8'h00); check(sd, 8'h05);
        wait_count(8'h00);
        seq(1'b1, 8'h9B, 8'h00); check(sd, 8'h00);
        hr(8'h9C); check(hd, 8'h00);
        for (i = 0; i < 17; i = i + 1) hw(8'h9B, i[7:0]);
        wait_count(8'h11);
        for (i = 0; i < 17; i = i + 1) seq(1'b1, 8'h9B, 8'h00);
        wait_count(8'h00);
        @(negedge mclk) external_storage_mode = 1'b1;
        hw(8'h90, 8'hFF); hr(8'h90); check(hd, 8'hFF);
        hw(8'h90, 8'h03); hw(8'hA2, 8'h9E); check(hdisc, 1'b1);
        hr(8'hA2); check(hd, 8'h9E);
        hw(8'h9A, 8'h80); host(1'b1, 8'hA0, 4'h0, 32'h4433_2211);
        hr(8'h9A); check(hd, 8'h84);
        for (i = 0; i < 256; i = i + 1) hw(8'h9B, i[7:0] ^ 8'hF0);
        wait_count(8'hFF);
        seq(1'b1, 8'h9B, 8'h00); check(sd, 8'hF0);
        wait_count(8'hFE);
        print_verdict;
    end
endmodule // command_block_array_queue_tb
